// ==== acc_clamp_top.v ====
`timescale 1ns/1ns
`include "acc_regs.vh"
module acc_clamp_top #(
  parameter TICK_CYCLES = `ACC_TICK_CYCLES,
  parameter TICK_HZ     = `ACC_TICK_HZ
) (
  input  wire               core_clk_i,
  input  wire               sys_rst_i,
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire        [7:0]  paddr,
  input  wire        [31:0] pwdata,
  output reg         [31:0] prdata,
  output reg                pready,
  output reg                pslverr,
  input  wire signed [15:0] cur_ref_i,
  input  wire signed [15:0] arm_cur_i,
  input  wire signed [15:0] speed_fb_i,
  input  wire signed [15:0] upper_external_clamp_i,
  input  wire signed [15:0] lower_external_clamp_i,
  output reg  signed [15:0] cur_dem_o,
  output reg  signed [15:0] phase_dem_o,
  output reg                sw_trip_o,
  output reg                hw_trip_o
);
  // Signed minimum and maximum on a common width
  function signed [33:0] f_min;
    input signed [33:0] a;
    input signed [33:0] b;
    begin
      f_min = (a < b) ? a : b;
    end
  endfunction

  function signed [33:0] f_max;
    input signed [33:0] a;
    input signed [33:0] b;
    begin
      f_max = (a > b) ? a : b;
    end
  endfunction

  function [16:0] f_abs;
    input signed [15:0] v;
    begin
      f_abs = v[15] ? (17'h0 - {v[15], v}) : {1'b0, v};
    end
  endfunction

  // Mapped offsets; anything else answers with an error
  function f_mapped;
    input [7:0] a;
    begin
      case (a)
        `ACC_OFS_CTRL:      f_mapped = 1'b1;
        `ACC_OFS_CUR_LIM:   f_mapped = 1'b1;
        `ACC_OFS_OL_TARGET: f_mapped = 1'b1;
        `ACC_OFS_OL_RAMP:   f_mapped = 1'b1;
        `ACC_OFS_SCALER:    f_mapped = 1'b1;
        `ACC_OFS_BP_HICUR:  f_mapped = 1'b1;
        `ACC_OFS_BP_LOCUR:  f_mapped = 1'b1;
        `ACC_OFS_PROF_LOW:  f_mapped = 1'b1;
        `ACC_OFS_KP:        f_mapped = 1'b1;
        `ACC_OFS_KI:        f_mapped = 1'b1;
        `ACC_OFS_MODEL:     f_mapped = 1'b1;
        `ACC_OFS_STATUS:    f_mapped = 1'b1;
        `ACC_OFS_POS_CLAMP: f_mapped = 1'b1;
        `ACC_OFS_NEG_CLAMP: f_mapped = 1'b1;
        `ACC_OFS_CUR_DEM:   f_mapped = 1'b1;
        `ACC_OFS_OL_LIMIT:  f_mapped = 1'b1;
        default:            f_mapped = 1'b0;
      endcase
    end
  endfunction

  // Settings only; status and monitors ignore plain writes
  function f_writable;
    input [7:0] a;
    begin
      case (a)
        `ACC_OFS_CTRL:      f_writable = 1'b1;
        `ACC_OFS_CUR_LIM:   f_writable = 1'b1;
        `ACC_OFS_OL_TARGET: f_writable = 1'b1;
        `ACC_OFS_OL_RAMP:   f_writable = 1'b1;
        `ACC_OFS_SCALER:    f_writable = 1'b1;
        `ACC_OFS_BP_HICUR:  f_writable = 1'b1;
        `ACC_OFS_BP_LOCUR:  f_writable = 1'b1;
        `ACC_OFS_PROF_LOW:  f_writable = 1'b1;
        `ACC_OFS_KP:        f_writable = 1'b1;
        `ACC_OFS_KI:        f_writable = 1'b1;
        `ACC_OFS_MODEL:     f_writable = 1'b1;
        default:            f_writable = 1'b0;
      endcase
    end
  endfunction

  reg        [1:0]  ctrl_q;
  reg        [15:0] cur_lim_q;
  reg        [15:0] ol_target_q;
  reg        [15:0] ol_ramp_q;
  reg        [15:0] master_clamp_scaler_q;
  reg        [15:0] bp_hicur_q;
  reg        [15:0] bp_locur_q;
  reg        [15:0] prof_low_q;
  reg        [15:0] kp_q;
  reg        [15:0] ki_q;
  reg        [15:0] model_q;
  reg               sw_trip_q;
  reg               hw_trip_q;
  reg signed [15:0] pos_clamp_q;
  reg signed [15:0] neg_clamp_q;
  reg        [31:0] div_q;
  reg               tick_q;
  wire       [15:0] ol_lim_w;
  wire              ol_full_w;
  wire              ol_reduce_w;
  wire signed [15:0] phase_w;

  // Control tick divider
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_q  <= 32'h0;
      tick_q <= 1'b0;
    end else if (div_q == TICK_CYCLES - 1) begin
      div_q  <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  wire [16:0] arm_abs_w = f_abs(arm_cur_i);
  wire [16:0] spd_abs_w = f_abs(speed_fb_i);

  // Speed dependent current profile
  wire        hicur_first_w = (bp_hicur_q <= bp_locur_q);
  wire [15:0] bp_a_w        = hicur_first_w ? bp_hicur_q : bp_locur_q;
  wire [15:0] bp_b_raw_w    = hicur_first_w ? bp_locur_q : bp_hicur_q;
  wire [16:0] bp_min_w      = {1'b0, bp_a_w} + {1'b0, `ACC_PCT_10};
  wire [16:0] bp_b_w        = ({1'b0, bp_b_raw_w} < bp_min_w) ? bp_min_w : {1'b0, bp_b_raw_w};
  wire signed [17:0] lvl_a_w = hicur_first_w ? $signed({2'b00, `ACC_PCT_150}) : $signed({2'b00, prof_low_q});
  wire signed [17:0] lvl_b_w = hicur_first_w ? $signed({2'b00, prof_low_q}) : $signed({2'b00, `ACC_PCT_150});
  wire signed [17:0] span_w  = $signed({1'b0, bp_b_w}) - $signed({2'b00, bp_a_w});
  wire signed [17:0] pos_w   = $signed({1'b0, spd_abs_w}) - $signed({2'b00, bp_a_w});
  wire signed [36:0] prod_w  = (lvl_b_w - lvl_a_w) * pos_w;
  wire signed [36:0] intp_w  = prod_w / span_w;
  reg  signed [33:0] prof_w;

  always @* begin
    if (!ctrl_q[`ACC_CTRL_PROF_EN])
      prof_w = {18'h0, `ACC_PCT_150};
    else if (pos_w <= 0)
      prof_w = {{16{lvl_a_w[17]}}, lvl_a_w};
    else if (pos_w >= span_w)
      prof_w = {{16{lvl_b_w[17]}}, lvl_b_w};
    else
      prof_w = {{16{lvl_a_w[17]}}, lvl_a_w} + intp_w[33:0];
  end

  // External clamps scaled by the master scaler
  wire signed [33:0] up_prod_w = upper_external_clamp_i * $signed({1'b0, master_clamp_scaler_q});
  wire signed [33:0] lo_prod_w = lower_external_clamp_i * $signed({1'b0, master_clamp_scaler_q});
  wire signed [33:0] up_ext_w  = up_prod_w / 34'sd10000;
  wire signed [33:0] lo_ext_w  = ctrl_q[`ACC_CTRL_DUAL_EN] ? lo_prod_w / 34'sd10000 : -up_ext_w;

  // Lowest of the four clamp levels
  wire signed [33:0] abs_w  = {18'h0, cur_lim_q};
  wire signed [33:0] ol_w   = f_min({18'h0, ol_lim_w}, {18'h0, `ACC_PCT_150});
  wire signed [33:0] lim_w  = f_min(f_min(abs_w, ol_w), prof_w);
  wire signed [33:0] hi_w   = f_min(lim_w, up_ext_w);
  wire signed [33:0] lo_w   = f_max(-lim_w, lo_ext_w);
  wire signed [33:0] ref_w  = {{18{cur_ref_i[15]}}, cur_ref_i};
  reg  signed [33:0] dem_w;

  always @* begin
    if (cur_lim_q == 16'h0 || ol_target_q == 16'h0)
      dem_w = 34'sh0;
    else if (hi_w < lo_w) begin
      if (hi_w < 0 && lo_w > 0)
        dem_w = 34'sh0;
      else if (hi_w >= 0)
        dem_w = hi_w;
      else
        dem_w = lo_w;
    end else
      dem_w = f_max(lo_w, f_min(hi_w, ref_w));
  end

  // Trip detection, evaluated every clock
  wire [32:0] model_cur_w = arm_abs_w * model_q;
  wire        sw_hit_w    = (arm_abs_w >= `ACC_PCT_300);
  wire        hw_hit_w    = (model_cur_w > 33'd150000000);

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pos_clamp_q <= 16'sh0;
      neg_clamp_q <= 16'sh0;
      cur_dem_o   <= 16'sh0;
      phase_dem_o <= 16'sh0;
      sw_trip_o   <= 1'b0;
      hw_trip_o   <= 1'b0;
    end else begin
      if (tick_q) begin
        pos_clamp_q <= hi_w[15:0];
        neg_clamp_q <= lo_w[15:0];
        cur_dem_o   <= dem_w[15:0];
      end
      phase_dem_o <= phase_w;
      sw_trip_o   <= sw_trip_q;
      hw_trip_o   <= hw_trip_q;
    end
  end

  acc_overload #(
    .TICK_HZ (TICK_HZ)
  ) u_overload (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .tick_i     (tick_q),
    .arm_abs_i  (arm_abs_w),
    .target_i   (ol_target_q),
    .ramp_ds_i  (ol_ramp_q),
    .ol_lim_o   (ol_lim_w),
    .full_o     (ol_full_w),
    .reduce_o   (ol_reduce_w)
  );

  acc_pi u_pi (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .tick_i     (tick_q),
    .dem_i      (cur_dem_o),
    .fb_i       (arm_cur_i),
    .kp_i       (kp_q),
    .ki_i       (ki_q),
    .phase_o    (phase_w)
  );

  // APB slave, one wait state so read data can come from a flop
  wire        acc_w  = psel && penable && !pready;
  wire        wr_w   = psel && penable && pready && pwrite;
  wire        w1c_w  = wr_w && (paddr == `ACC_OFS_STATUS);
  reg  [31:0] rd_w;
  reg         hit_w;

  always @* begin
    hit_w = f_mapped(paddr);
    case (paddr)
      `ACC_OFS_CTRL:      rd_w = {30'h0, ctrl_q};
      `ACC_OFS_CUR_LIM:   rd_w = {16'h0, cur_lim_q};
      `ACC_OFS_OL_TARGET: rd_w = {16'h0, ol_target_q};
      `ACC_OFS_OL_RAMP:   rd_w = {16'h0, ol_ramp_q};
      `ACC_OFS_SCALER:    rd_w = {16'h0, master_clamp_scaler_q};
      `ACC_OFS_BP_HICUR:  rd_w = {16'h0, bp_hicur_q};
      `ACC_OFS_BP_LOCUR:  rd_w = {16'h0, bp_locur_q};
      `ACC_OFS_PROF_LOW:  rd_w = {16'h0, prof_low_q};
      `ACC_OFS_KP:        rd_w = {16'h0, kp_q};
      `ACC_OFS_KI:        rd_w = {16'h0, ki_q};
      `ACC_OFS_MODEL:     rd_w = {16'h0, model_q};
      `ACC_OFS_STATUS:    rd_w = {28'h0, ol_reduce_w, ol_full_w, hw_trip_q, sw_trip_q};
      `ACC_OFS_POS_CLAMP: rd_w = {{16{pos_clamp_q[15]}}, pos_clamp_q};
      `ACC_OFS_NEG_CLAMP: rd_w = {{16{neg_clamp_q[15]}}, neg_clamp_q};
      `ACC_OFS_CUR_DEM:   rd_w = {{16{cur_dem_o[15]}}, cur_dem_o};
      `ACC_OFS_OL_LIMIT:  rd_w = {16'h0, ol_lim_w};
      default: begin
        rd_w  = 32'h0;
        hit_w = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc_w;
      pslverr <= acc_w && !hit_w;
      prdata  <= (acc_w && !pwrite) ? rd_w : 32'h0;
    end
  end

  // Trip flags: a new hit wins over a clear in the same cycle
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sw_trip_q <= 1'b0;
      hw_trip_q <= 1'b0;
    end else begin
      sw_trip_q <= sw_hit_w || (sw_trip_q && !(w1c_w && pwdata[`ACC_ST_SW_TRIP]));
      hw_trip_q <= hw_hit_w || (hw_trip_q && !(w1c_w && pwdata[`ACC_ST_HW_TRIP]));
    end
  end

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q                <= `ACC_RST_CTRL;
      cur_lim_q             <= `ACC_RST_CUR_LIM;
      ol_target_q           <= `ACC_RST_OL_TARGET;
      ol_ramp_q             <= `ACC_RST_OL_RAMP;
      master_clamp_scaler_q <= `ACC_RST_SCALER;
      bp_hicur_q            <= `ACC_RST_BP_HICUR;
      bp_locur_q            <= `ACC_RST_BP_LOCUR;
      prof_low_q            <= `ACC_RST_PROF_LOW;
      kp_q                  <= `ACC_RST_KP;
      ki_q                  <= `ACC_RST_KI;
      model_q               <= `ACC_RST_MODEL;
    end else if (wr_w && f_writable(paddr)) begin
      case (paddr)
        `ACC_OFS_CTRL:      ctrl_q                <= pwdata[1:0];
        `ACC_OFS_CUR_LIM:   cur_lim_q             <= pwdata[15:0];
        `ACC_OFS_OL_TARGET: ol_target_q           <= pwdata[15:0];
        `ACC_OFS_OL_RAMP:   ol_ramp_q             <= pwdata[15:0];
        `ACC_OFS_SCALER:    master_clamp_scaler_q <= pwdata[15:0];
        `ACC_OFS_BP_HICUR:  bp_hicur_q            <= pwdata[15:0];
        `ACC_OFS_BP_LOCUR:  bp_locur_q            <= pwdata[15:0];
        `ACC_OFS_PROF_LOW:  prof_low_q            <= pwdata[15:0];
        `ACC_OFS_KP:        kp_q                  <= pwdata[15:0];
        `ACC_OFS_KI:        ki_q                  <= pwdata[15:0];
        `ACC_OFS_MODEL:     model_q               <= pwdata[15:0];
        default:            ctrl_q                <= ctrl_q;
      endcase
    end
  end
endmodule // acc_clamp_top

// ==== acc_regs.vh ====
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
// Register byte offsets
`define ACC_OFS_CTRL      8'h00
`define ACC_OFS_CUR_LIM   8'h04
`define ACC_OFS_OL_TARGET 8'h08
`define ACC_OFS_OL_RAMP   8'h0c
`define ACC_OFS_SCALER    8'h10
`define ACC_OFS_BP_HICUR  8'h14
`define ACC_OFS_BP_LOCUR  8'h18
`define ACC_OFS_PROF_LOW  8'h1c
`define ACC_OFS_KP        8'h20
`define ACC_OFS_KI        8'h24
`define ACC_OFS_MODEL     8'h28
`define ACC_OFS_STATUS    8'h2c
`define ACC_OFS_POS_CLAMP 8'h30
`define ACC_OFS_NEG_CLAMP 8'h34
`define ACC_OFS_CUR_DEM   8'h38
`define ACC_OFS_OL_LIMIT  8'h3c
// Field positions
`define ACC_CTRL_PROF_EN  0
`define ACC_CTRL_DUAL_EN  1
`define ACC_ST_SW_TRIP    0
`define ACC_ST_HW_TRIP    1
`define ACC_ST_OL_FULL    2
`define ACC_ST_OL_REDUCE  3
// Reset values, percentages in 0.01 % steps
`define ACC_RST_CTRL      2'h0
`define ACC_RST_CUR_LIM   16'h3a98
`define ACC_RST_OL_TARGET 16'h2710
`define ACC_RST_OL_RAMP   16'h00c8
`define ACC_RST_SCALER    16'h2710
`define ACC_RST_BP_HICUR  16'h2710
`define ACC_RST_BP_LOCUR  16'h2710
`define ACC_RST_PROF_LOW  16'h2710
`define ACC_RST_KP        16'h0100
`define ACC_RST_KI        16'h0010
`define ACC_RST_MODEL     16'h2710
// Levels
`define ACC_PCT_150       16'h3a98
`define ACC_PCT_300       17'h07530
`define ACC_PCT_100       16'h2710
`define ACC_PCT_10        16'h03e8
// Timing
`define ACC_CLK_HZ        25000000
`define ACC_TICK_HZ       1000
`define ACC_TICK_CYCLES   (`ACC_CLK_HZ / `ACC_TICK_HZ)
`define ACC_DWELL_S       25
`endif

// ==== acc_overload.v ====
`timescale 1ns/1ns
`include "acc_regs.vh"
module acc_overload #(
  parameter TICK_HZ = `ACC_TICK_HZ
) (
  input  wire               core_clk_i,
  input  wire               sys_rst_i,
  input  wire               tick_i,
  input  wire        [16:0] arm_abs_i,
  input  wire        [15:0] target_i,
  input  wire        [15:0] ramp_ds_i,
  output reg         [15:0] ol_lim_o,
  output reg                full_o,
  output reg                reduce_o
);
  wire        [39:0] cap_w   = (40'd15000 - {24'h0, target_i}) * `ACC_DWELL_S * TICK_HZ;
  wire        [31:0] ramp_w  = ({16'h0, ramp_ds_i} * TICK_HZ) / 10;
  wire signed [40:0] diff_w  = $signed({24'h0, arm_abs_i}) - $signed({25'h0, target_i});
  reg         [39:0] acc_q;
  reg         [31:0] phase_q;
  wire signed [41:0] sum_w   = $signed({2'b00, acc_q}) + diff_w;
  wire        [31:0] phase_w = phase_q + 32'd10000;
  wire               step_w  = (phase_w >= ramp_w);
  wire               full_w  = (acc_q >= cap_w);

  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_q    <= 40'h0;
      phase_q  <= 32'h0;
      ol_lim_o <= `ACC_PCT_150;
      full_o   <= 1'b0;
      reduce_o <= 1'b0;
    end else if (tick_i) begin
      // Fill above target, drain below, saturate at both ends
      if (sum_w < 0)
        acc_q <= 40'h0;
      else if (sum_w > $signed({2'b00, cap_w}))
        acc_q <= cap_w;
      else
        acc_q <= sum_w[39:0];
      full_o   <= full_w;
      reduce_o <= full_w && (ol_lim_o > target_i);
      phase_q  <= step_w ? phase_w - ramp_w : phase_w;
      if (full_w) begin
        if (ol_lim_o > target_i && step_w)
          ol_lim_o <= ol_lim_o - 16'h1;
        else if (ol_lim_o < target_i)
          ol_lim_o <= target_i;
      end else if (arm_abs_i < {1'b0, target_i} && step_w) begin
        // Full 150 % only once the integrator is empty
        if (ol_lim_o < `ACC_PCT_150 - 16'h1 || (acc_q == 40'h0 && ol_lim_o < `ACC_PCT_150))
          ol_lim_o <= ol_lim_o + 16'h1;
      end
    end
  end
endmodule // acc_overload

// ==== acc_pi.v ====
`timescale 1ns/1ns
module acc_pi (
  input  wire               core_clk_i,
  input  wire               sys_rst_i,
  input  wire               tick_i,
  input  wire signed [15:0] dem_i,
  input  wire signed [15:0] fb_i,
  input  wire        [15:0] kp_i,
  input  wire        [15:0] ki_i,
  output reg  signed [15:0] phase_o
);
  reg  signed [31:0] integ_q;
  wire signed [16:0] err_w  = dem_i - fb_i;
  wire signed [33:0] p_w    = (err_w * $signed({1'b0, kp_i})) >>> 8;
  wire signed [33:0] i_w    = (err_w * $signed({1'b0, ki_i})) >>> 8;
  wire signed [34:0] in_w   = integ_q + i_w;
  wire signed [31:0] in_s   = (in_w > 35'sd32767) ? 32'sd32767 : (in_w < -35'sd32767) ? -32'sd32767 : in_w[31:0];
  wire signed [34:0] out_w  = p_w + in_s;

  // Integrator saturates to keep wind-up bounded
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      integ_q <= 32'sh0;
      phase_o <= 16'sh0;
    end else if (tick_i) begin
      integ_q <= in_s;
      if (out_w > 35'sd32767)
        phase_o <= 16'sh7fff;
      else if (out_w < -35'sd32767)
        phase_o <= -16'sh7fff;
      else
        phase_o <= out_w[15:0];
    end
  end
endmodule // acc_pi

// ==== acc_far_side.sv ====
`timescale 1ns/1ns
// Speed amplifier output and measured current, one cycle late
module acc_far_side (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic signed [15:0] ref_set_i,
  input  wire logic signed [15:0] arm_set_i,
  output logic      signed [15:0] cur_ref_o,
  output logic      signed [15:0] arm_cur_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      cur_ref_o <= 16'sh0;
      arm_cur_o <= 16'sh0;
    end else begin
      cur_ref_o <= ref_set_i;
      arm_cur_o <= arm_set_i;
    end
  end
endmodule // acc_far_side

// ==== acc_clamp_checker.sv ====
`timescale 1ns/1ns
module acc_clamp_checker #(
  parameter TICK_CYCLES = 4,
  parameter TICK_HZ     = 10
) (
  input wire logic               core_clk_i,
  input wire logic               sys_rst_i,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic        [7:0]  paddr,
  input wire logic        [31:0] pwdata,
  input wire logic        [31:0] prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic signed [15:0] cur_ref_i,
  input wire logic signed [15:0] arm_cur_i,
  input wire logic signed [15:0] speed_fb_i,
  input wire logic signed [15:0] upper_external_clamp_i,
  input wire logic signed [15:0] lower_external_clamp_i,
  input wire logic signed [15:0] cur_dem_o,
  input wire logic signed [15:0] phase_dem_o,
  input wire logic               sw_trip_o,
  input wire logic               hw_trip_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Hardware trip threshold assumes the default model ratio
  wire sw_hit = arm_cur_i >= 16'sh7530 || arm_cur_i <= -16'sh7530;
  wire hw_hit = arm_cur_i > 16'sh3a98 || arm_cur_i < -16'sh3a98;
  logic [3:0] sw_sr_q;
  logic [3:0] hw_sr_q;
  always @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sw_sr_q <= 4'h0;
      hw_sr_q <= 4'h0;
    end else begin
      sw_sr_q <= {sw_sr_q[2:0], sw_hit};
      hw_sr_q <= {hw_sr_q[2:0], hw_hit};
    end
  end
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  AST_SW_TRIP: assert property (sw_hit |-> ##[1:3] sw_trip_o)
    else $error("software trip missing");
  AST_SW_CAUSE: assert property ($rose(sw_trip_o) |-> sw_sr_q != 4'h0)
    else $error("software trip without cause");
  AST_HW_TRIP: assert property (hw_hit |-> ##[1:3] hw_trip_o)
    else $error("hardware trip missing");
  AST_HW_CAUSE: assert property ($rose(hw_trip_o) |-> hw_sr_q != 4'h0)
    else $error("hardware trip without cause");
  AST_DEM_CAP: assert property (cur_dem_o <= 16'sh3a98 && cur_dem_o >= -16'sh3a98)
    else $error("demand above 150 percent");
  AST_DEM_HOLD: assert property ($changed(cur_dem_o) |=> $stable(cur_dem_o) [*3])
    else $error("demand moved between ticks");
  AST_PHASE_HOLD: assert property ($changed(phase_dem_o) |=> $stable(phase_dem_o) [*3])
    else $error("phase moved between ticks");
endmodule // acc_clamp_checker
bind acc_clamp_top acc_clamp_checker #(.TICK_CYCLES(TICK_CYCLES), .TICK_HZ(TICK_HZ)) u_chk (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cur_ref_i(cur_ref_i), .arm_cur_i(arm_cur_i), .speed_fb_i(speed_fb_i),
  .upper_external_clamp_i(upper_external_clamp_i), .lower_external_clamp_i(lower_external_clamp_i),
  .cur_dem_o(cur_dem_o), .phase_dem_o(phase_dem_o), .sw_trip_o(sw_trip_o), .hw_trip_o(hw_trip_o));

// ==== acc_clamp_top_test.sv ====
`timescale 1ns/1ns
`include "acc_regs.vh"
module acc_clamp_top_test;
  localparam int TC = 4;
  logic               core_clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, er, sw_trip, hw_trip;
  logic        [7:0]  paddr;
  logic        [31:0] pwdata, prdata, rd;
  logic signed [15:0] ref_set, arm_set, spd, upx, lox, cur_ref, arm_cur, cur_dem, phase;
  int                 fail_count, samples_checked;
  acc_clamp_top #(.TICK_CYCLES(TC), .TICK_HZ(10)) DUT (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cur_ref_i(cur_ref), .arm_cur_i(arm_cur), .speed_fb_i(spd), .upper_external_clamp_i(upx),
    .lower_external_clamp_i(lox), .cur_dem_o(cur_dem), .phase_dem_o(phase), .sw_trip_o(sw_trip),
    .hw_trip_o(hw_trip));
  acc_far_side u_far (.clk_i(core_clk_i), .rst_i(sys_rst_i), .ref_set_i(ref_set), .arm_set_i(arm_set),
    .cur_ref_o(cur_ref), .arm_cur_o(arm_cur));
  initial begin
    core_clk_i = 0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1;
    n = 0;
    do begin @(posedge core_clk_i); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin chk(16'h0, 16'h1); give_verdict; end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1, a, {16'h0, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    apb(0, a, 32'h0);
    chk(rd[15:0], e);
  endtask
  // Settle past the edge so registered outputs are stable
  task automatic ticks(input int n);
    repeat (n * TC) @(posedge core_clk_i);
    #1;
  endtask
  task automatic drv(input logic [15:0] r, a, u, l, s);
    @(posedge core_clk_i);
    ref_set <= r; arm_set <= a; upx <= u; lox <= l; spd <= s;
  endtask
  task automatic dem(input logic [15:0] e);
    ticks(3);
    chk(cur_dem, e);
  endtask
  task automatic waitbit(input int b);
    int n;
    n = 0;
    do begin apb(0, `ACC_OFS_STATUS, 32'h0); n++; end while (rd[b] !== 1'b1 && n < 40);
    chk({15'h0, rd[b]}, 16'h1);
    if (n >= 40) give_verdict;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk_i);
    chk(16'h0, 16'h1);
    give_verdict;
  end
  initial begin
    sys_rst_i = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    ref_set = 0; arm_set = 0; spd = 0; upx = 16'h2710; lox = 16'hd8f0;
    fail_count = 0; samples_checked = 0;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 0;
    rdc(`ACC_OFS_CUR_LIM, `ACC_RST_CUR_LIM);
    rdc(`ACC_OFS_OL_TARGET, `ACC_RST_OL_TARGET);
    rdc(`ACC_OFS_OL_RAMP, `ACC_RST_OL_RAMP);
    rdc(`ACC_OFS_SCALER, `ACC_RST_SCALER);
    rdc(`ACC_OFS_KP, `ACC_RST_KP);
    rdc(`ACC_OFS_MODEL, `ACC_RST_MODEL);
    apb(0, 8'h40, 32'h0);
    chk({15'h0, er}, 16'h1);
    drv(16'h0bb8, 0, 16'h2710, 16'hd8f0, 0); dem(16'h0bb8);
    chk({15'h0, phase > 16'sh0}, 16'h1);
    wr(`ACC_OFS_CUR_LIM, 16'h1f40); drv(16'h2ee0, 0, 16'h2710, 16'hd8f0, 0); dem(16'h1f40);
    rdc(`ACC_OFS_POS_CLAMP, 16'h1f40);
    rdc(`ACC_OFS_NEG_CLAMP, 16'he0c0);
    wr(`ACC_OFS_CUR_LIM, 16'h0); dem(16'h0);
    wr(`ACC_OFS_CUR_LIM, 16'h3a98); wr(`ACC_OFS_OL_TARGET, 16'h0); dem(16'h0);
    wr(`ACC_OFS_OL_TARGET, 16'h2710);
    wr(`ACC_OFS_SCALER, 16'h1388); dem(16'h1388);
    drv(16'hd120, 0, 16'h2710, 16'hd8f0, 0); dem(16'hec78);
    wr(`ACC_OFS_CTRL, 16'h2); drv(16'hd120, 0, 16'h2710, 16'hf830, 0); dem(16'hfc18);
    drv(16'hd120, 0, 16'hfc18, 16'h03e8, 0); dem(16'h0);
    wr(`ACC_OFS_CTRL, 16'h1); wr(`ACC_OFS_SCALER, 16'h3a98);
    wr(`ACC_OFS_BP_HICUR, 16'h07d0); wr(`ACC_OFS_BP_LOCUR, 16'h1770); wr(`ACC_OFS_PROF_LOW, 16'h1388);
    drv(16'h36b0, 0, 16'h2710, 16'hd8f0, 16'h0fa0); dem(16'h2710);
    drv(16'h36b0, 0, 16'h2710, 16'hd8f0, 16'h1b58); dem(16'h1388);
    wr(`ACC_OFS_BP_LOCUR, 16'h09c4); drv(16'h36b0, 0, 16'h2710, 16'hd8f0, 16'h09c4); dem(16'h2710);
    wr(`ACC_OFS_CTRL, 16'h0);
    // Overload at 150 % with default target fills in 250 ticks at this tick rate
    drv(16'h3a98, 16'h3a98, 16'h2710, 16'hd8f0, 0);
    ticks(240);
    apb(0, `ACC_OFS_STATUS, 32'h0);
    chk({15'h0, rd[`ACC_ST_OL_FULL]}, 16'h0);
    waitbit(`ACC_ST_OL_FULL);
    ticks(100);
    apb(0, `ACC_OFS_OL_LIMIT, 32'h0);
    chk({15'h0, rd[15:0] >= 16'h3a20 && rd[15:0] <= 16'h3a48}, 16'h1);
    ticks(5000);
    rdc(`ACC_OFS_OL_LIMIT, 16'h2710);
    chk(cur_dem, 16'h2710);
    drv(16'h3a98, 16'h1388, 16'h2710, 16'hd8f0, 0);
    ticks(20);
    apb(0, `ACC_OFS_OL_LIMIT, 32'h0);
    chk({15'h0, rd[15:0] > 16'h2710 && rd[15:0] < 16'h3a98}, 16'h1);
    drv(0, 16'h4e20, 16'h2710, 16'hd8f0, 0); ticks(1);
    chk({14'h0, sw_trip, hw_trip}, 16'h1);
    drv(0, 0, 16'h2710, 16'hd8f0, 0);
    wr(`ACC_OFS_STATUS, 16'h3); ticks(1);
    chk({15'h0, hw_trip}, 16'h0);
    drv(0, 16'h752f, 16'h2710, 16'hd8f0, 0); ticks(1);
    chk({15'h0, sw_trip}, 16'h0);
    drv(0, 16'h8ad0, 16'h2710, 16'hd8f0, 0); ticks(1);
    chk({15'h0, sw_trip}, 16'h1);
    give_verdict;
  end
endmodule // acc_clamp_top_test
